/* rtc_pwr_pkg.sv */
// Constants, register map and carrier types for the always-on power and wake control.
// Assumes a single 25 MHz system clock; the 32.768 kHz rate exists only as an enable pulse.
package rtc_pwr_pkg;

  // Clock rates and the slow-tick divider
  localparam int unsigned SYS_CLK_HZ     = 25_000_000;
  localparam int unsigned RTC_CLK_HZ     = 32_768;
  localparam int unsigned RTC_DIV_CYCLES = (SYS_CLK_HZ + RTC_CLK_HZ / 2) / RTC_CLK_HZ;

  // Least wake pulse, in ns, and the same in slow ticks (rounded up, at least one)
  localparam longint unsigned WAKE_PULSE_MIN_NS = 30_500;
  localparam longint unsigned WAKE_PULSE_RAW    =
    (WAKE_PULSE_MIN_NS * RTC_CLK_HZ + 64'd999_999_999) / 64'd1_000_000_000;
  localparam int unsigned WAKE_PULSE_TICKS = (WAKE_PULSE_RAW < 1) ? 1 : int'(WAKE_PULSE_RAW);

  // Register writes land this many slow ticks after the bus accepts them
  localparam int unsigned WRITE_APPLY_TICKS = 2;
  // Slow ticks for which the rest of the system is held in reset after power-good rises
  localparam int unsigned SYS_RESET_TICKS   = 2;

  // Avalon-MM geometry and byte addresses
  localparam int unsigned AVMM_ADDR_W = 16;
  localparam int unsigned AVMM_DATA_W = 32;
  localparam int unsigned REG_W       = 16;
  localparam logic [AVMM_ADDR_W-1:0] PMGT_OFFSET   = 16'h1930;
  localparam logic [AVMM_ADDR_W-1:0] STATUS_OFFSET = 16'h1934;

  // Power-management register fields
  localparam int unsigned CLKOUT_EN_BIT = 0;
  localparam int unsigned REG_PD_BIT    = 1;
  localparam int unsigned REF_PD_BIT    = 2;
  localparam int unsigned WAKE_DIR_BIT  = 3;
  localparam int unsigned WAKE_OUT_BIT  = 4;
  localparam logic [REG_W-1:0] PMGT_RESET      = 16'h0010;
  localparam logic [REG_W-1:0] PMGT_WRITE_MASK = 16'h001f;

  // Status register fields
  localparam int unsigned ST_POWER_GOOD_BIT = 0;
  localparam int unsigned ST_REG_ON_BIT     = 1;
  localparam int unsigned ST_REF_ON_BIT     = 2;
  localparam int unsigned ST_WAKE_LEVEL_BIT = 3;
  localparam int unsigned ST_PENDING_BIT    = 4;
  localparam int unsigned ST_ALARM_BIT      = 5;
  localparam int unsigned ST_STATE_LSB      = 8;

  typedef struct packed {
    logic                   read;
    logic                   write;
    logic [AVMM_ADDR_W-1:0] address;
    logic [AVMM_DATA_W-1:0] writedata;
    logic [3:0]             byteenable;
  } avmm_req_type;

  typedef struct packed {
    logic coreRegulatorEnable;
    logic analogPorEnable;
    logic bandgapEnable;
    logic powerGood;
    logic isolation;
    logic systemReset_n;
    logic rtcAccessEnable;
    logic clockOutEnable;
  } power_ctl_type;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_DOWN,
    PWR_RAMP,
    PWR_SETTLE
  } pwr_state_type;

endpackage

/* rtc_tick_divider.sv */
// Divides the system clock into a one-cycle enable at the slow clock-domain rate.
// Assumes clk_sys is free running; rst_n is the always-on power-on reset.
`timescale 1ns/1ns
module rtc_tick_divider #(
  parameter int unsigned DIV = rtc_pwr_pkg::RTC_DIV_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      tick
);
  import rtc_pwr_pkg::*;

  localparam int unsigned CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

  logic [CNT_W-1:0] count_r;

  if (DIV < 2) begin : gBadDiv
    $error("rtc_tick_divider: DIV must be at least 2");
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else if (count_r == LAST) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (count_r == LAST);
    end
  end

endmodule

/* rtc_power_wake_control.sv */
// Always-on power and wake control: register slave, power-down/wake sequencer, wake pin.
// Assumes an Avalon-MM master on clk_sys and rst_n driven by the always-on power-on reset.
`timescale 1ns/1ns
module rtc_power_wake_control #(
  parameter int unsigned TICK_DIV        = rtc_pwr_pkg::RTC_DIV_CYCLES,
  parameter int unsigned APPLY_TICKS     = rtc_pwr_pkg::WRITE_APPLY_TICKS,
  parameter int unsigned RESET_TICKS     = rtc_pwr_pkg::SYS_RESET_TICKS,
  parameter int unsigned WAKE_TICKS      = rtc_pwr_pkg::WAKE_PULSE_TICKS
) (
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire rtc_pwr_pkg::avmm_req_type       avmmReq,
  output logic [rtc_pwr_pkg::AVMM_DATA_W-1:0]  avmmReadData,
  output logic                                 avmmWaitRequest,
  input  wire logic                            wakeIn,
  output logic                                 wakeOut,
  output logic                                 wakeOutEnable,
  input  wire logic                            alarmIrq,
  input  wire logic                            coreVoltageOk,
  output rtc_pwr_pkg::power_ctl_type           powerCtl
);
  import rtc_pwr_pkg::*;

  localparam int unsigned TCNT_W = 4;
  localparam logic [TCNT_W-1:0] APPLY_LAST = TCNT_W'(APPLY_TICKS - 1);
  localparam logic [TCNT_W-1:0] RESET_LAST = TCNT_W'(RESET_TICKS - 1);
  localparam logic [TCNT_W-1:0] WAKE_LAST  = TCNT_W'(WAKE_TICKS - 1);

  if (APPLY_TICKS < 1 || APPLY_TICKS > 15) begin : gBadApply
    $error("APPLY_TICKS must lie in 1..15");
  end
  if (RESET_TICKS < 1 || RESET_TICKS > 15) begin : gBadReset
    $error("RESET_TICKS must lie in 1..15");
  end
  if (WAKE_TICKS < 1 || WAKE_TICKS > 15) begin : gBadWake
    $error("WAKE_TICKS must lie in 1..15");
  end

  // Slow clock-domain enable
  logic tick;

  rtc_tick_divider #(
    .DIV (TICK_DIV)
  ) uTickDiv (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .tick    (tick)
  );

  // Pin and analog inputs cross two flip-flops before any use
  logic wakeMeta_r;
  logic wakeSync_r;
  logic alarmMeta_r;
  logic alarmSync_r;
  logic vokMeta_r;
  logic vokSync_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wakeMeta_r  <= 1'b0;
      wakeSync_r  <= 1'b0;
      alarmMeta_r <= 1'b0;
      alarmSync_r <= 1'b0;
      vokMeta_r   <= 1'b0;
      vokSync_r   <= 1'b0;
    end else begin
      wakeMeta_r  <= wakeIn;
      wakeSync_r  <= wakeMeta_r;
      alarmMeta_r <= alarmIrq;
      alarmSync_r <= alarmMeta_r;
      vokMeta_r   <= coreVoltageOk;
      vokSync_r   <= vokMeta_r;
    end
  end

  // Registers and sequencer state
  logic [REG_W-1:0]  pmgt_r;
  logic [REG_W-1:0]  pending_r;
  logic              pendValid_r;
  logic [TCNT_W-1:0] applyCnt_r;
  logic [TCNT_W-1:0] wakeCnt_r;
  logic [TCNT_W-1:0] rstCnt_r;
  pwr_state_type     state_r;
  pwr_state_type     state_nxt;
  logic              alarmSeen_r;

  function automatic logic anyPowerDown(input logic [REG_W-1:0] v);
    anyPowerDown = v[REG_PD_BIT] | v[REF_PD_BIT];
  endfunction

  function automatic logic [REG_W-1:0] mergeWrite(input logic [REG_W-1:0] old,
                                                  input logic [AVMM_DATA_W-1:0] wd,
                                                  input logic [3:0] be);
    logic [REG_W-1:0] v;
    v = old;
    if (be[0]) begin
      v = wd[REG_W-1:0];
    end
    mergeWrite = v & PMGT_WRITE_MASK;
  endfunction

  // Wake pin counts only as input, active high, after being seen high on slow ticks
  logic pinWakeLevel;
  logic wakeReq;
  assign pinWakeLevel = wakeSync_r & ~pmgt_r[WAKE_DIR_BIT];
  assign wakeReq = tick & ((pinWakeLevel & (wakeCnt_r == WAKE_LAST)) | alarmSync_r);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wakeCnt_r <= '0;
    end else if (!pinWakeLevel) begin
      wakeCnt_r <= '0;
    end else if (tick && wakeCnt_r != WAKE_LAST) begin
      wakeCnt_r <= wakeCnt_r + 1'b1;
    end
  end

  // Sticky alarm indication for status; a new alarm wins over the clear on a tick in RUN
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alarmSeen_r <= 1'b0;
    end else if (alarmSync_r) begin
      alarmSeen_r <= 1'b1;
    end else if (state_r == PWR_RUN && tick) begin
      alarmSeen_r <= 1'b0;
    end
  end

  // Bus slave: one answer per request, waitrequest low for exactly one cycle
  logic reqSeen;
  logic reqAccept;
  logic isPmgt;
  logic isStatus;
  assign reqSeen   = avmmReq.read | avmmReq.write;
  assign isPmgt    = (avmmReq.address == PMGT_OFFSET);
  assign isStatus  = (avmmReq.address == STATUS_OFFSET);
  // A second write to the power register stalls until the first one has landed
  assign reqAccept = reqSeen & avmmWaitRequest & ~(avmmReq.write & isPmgt & pendValid_r);

  logic [REG_W-1:0] statusWord;
  always_comb begin
    statusWord = '0;
    statusWord[ST_POWER_GOOD_BIT] = powerCtl.powerGood;
    statusWord[ST_REG_ON_BIT]     = powerCtl.coreRegulatorEnable;
    statusWord[ST_REF_ON_BIT]     = powerCtl.bandgapEnable;
    statusWord[ST_WAKE_LEVEL_BIT] = wakeSync_r;
    statusWord[ST_PENDING_BIT]    = pendValid_r;
    statusWord[ST_ALARM_BIT]      = alarmSeen_r;
    statusWord[ST_STATE_LSB +: 2] = state_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avmmWaitRequest <= 1'b1;
    end else begin
      avmmWaitRequest <= ~reqAccept;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avmmReadData <= '0;
    end else if (reqAccept && avmmReq.read) begin
      if (isPmgt) begin
        avmmReadData <= {{(AVMM_DATA_W-REG_W){1'b0}}, pmgt_r & PMGT_WRITE_MASK};
      end else if (isStatus) begin
        avmmReadData <= {{(AVMM_DATA_W-REG_W){1'b0}}, statusWord};
      end else begin
        avmmReadData <= '0;
      end
    end
  end

  // Accepted writes wait for the slow clock before landing
  logic applyNow;
  assign applyNow = pendValid_r & tick & (applyCnt_r == APPLY_LAST);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pendValid_r <= 1'b0;
      pending_r   <= PMGT_RESET;
      applyCnt_r  <= '0;
    end else if (reqAccept && avmmReq.write && isPmgt) begin
      pendValid_r <= 1'b1;
      pending_r   <= mergeWrite(pmgt_r, avmmReq.writedata, avmmReq.byteenable);
      applyCnt_r  <= '0;
    end else if (applyNow) begin
      pendValid_r <= 1'b0;
    end else if (pendValid_r && tick) begin
      applyCnt_r  <= applyCnt_r + 1'b1;
    end
  end

  // The register lands late; a wake clears both power-down bits so the core stays up
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pmgt_r <= PMGT_RESET;
    end else begin
      if (applyNow) begin
        pmgt_r <= pending_r;
      end
      if (state_r == PWR_DOWN && wakeReq) begin
        pmgt_r[REG_PD_BIT] <= 1'b0;
        pmgt_r[REF_PD_BIT] <= 1'b0;
      end
    end
  end

  // Power sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PWR_RUN: begin
        if (anyPowerDown(pmgt_r)) begin
          state_nxt = PWR_DOWN;
        end
      end
      PWR_DOWN: begin
        if (wakeReq) begin
          state_nxt = PWR_RAMP;
        end
      end
      PWR_RAMP: begin
        if (vokSync_r) begin
          state_nxt = PWR_SETTLE;
        end
      end
      PWR_SETTLE: begin
        if (tick && rstCnt_r == RESET_LAST) begin
          state_nxt = PWR_RUN;
        end
      end
      default: begin
        state_nxt = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PWR_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstCnt_r <= '0;
    end else if (state_r != PWR_SETTLE) begin
      rstCnt_r <= '0;
    end else if (tick && rstCnt_r != RESET_LAST) begin
      rstCnt_r <= rstCnt_r + 1'b1;
    end
  end

  // Outputs follow the next state so they change on the same edge as the state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      powerCtl.coreRegulatorEnable <= 1'b1;
      powerCtl.analogPorEnable     <= 1'b1;
      powerCtl.bandgapEnable       <= 1'b1;
      powerCtl.powerGood           <= 1'b1;
      powerCtl.isolation           <= 1'b0;
      powerCtl.systemReset_n       <= 1'b1;
      powerCtl.rtcAccessEnable     <= 1'b1;
      powerCtl.clockOutEnable      <= 1'b0;
    end else begin
      // Clock output gate lives here so the whole carrier has one driver
      powerCtl.clockOutEnable <= pmgt_r[CLKOUT_EN_BIT];
      case (state_nxt)
        PWR_DOWN: begin
          powerCtl.coreRegulatorEnable <= 1'b0;
          powerCtl.analogPorEnable     <= 1'b0;
          powerCtl.bandgapEnable       <= ~pmgt_r[REF_PD_BIT];
          powerCtl.powerGood           <= 1'b0;
          powerCtl.isolation           <= 1'b1;
          powerCtl.systemReset_n       <= 1'b0;
          powerCtl.rtcAccessEnable     <= 1'b0;
        end
        PWR_RAMP: begin
          powerCtl.coreRegulatorEnable <= 1'b1;
          powerCtl.analogPorEnable     <= 1'b1;
          powerCtl.bandgapEnable       <= 1'b1;
          powerCtl.powerGood           <= 1'b0;
          powerCtl.isolation           <= 1'b1;
          powerCtl.systemReset_n       <= 1'b0;
          powerCtl.rtcAccessEnable     <= 1'b0;
        end
        PWR_SETTLE: begin
          powerCtl.coreRegulatorEnable <= 1'b1;
          powerCtl.analogPorEnable     <= 1'b1;
          powerCtl.bandgapEnable       <= 1'b1;
          powerCtl.powerGood           <= 1'b1;
          powerCtl.isolation           <= 1'b0;
          powerCtl.systemReset_n       <= 1'b0;
          powerCtl.rtcAccessEnable     <= 1'b1;
        end
        default: begin
          powerCtl.coreRegulatorEnable <= 1'b1;
          powerCtl.analogPorEnable     <= 1'b1;
          powerCtl.bandgapEnable       <= 1'b1;
          powerCtl.powerGood           <= 1'b1;
          powerCtl.isolation           <= 1'b0;
          powerCtl.systemReset_n       <= 1'b1;
          powerCtl.rtcAccessEnable     <= 1'b1;
        end
      endcase
    end
  end

  // Open-drain wake pin: the only level ever driven is low, the pull-up makes the high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wakeOut       <= 1'b0;
      wakeOutEnable <= 1'b0;
    end else begin
      wakeOut       <= 1'b0;
      wakeOutEnable <= pmgt_r[WAKE_DIR_BIT] & ~pmgt_r[WAKE_OUT_BIT];
    end
  end

endmodule

/* rtc_power_wake_control_props.sv */
// Port checker for the always-on power and wake control.
// Assumes it is bound onto rtc_power_wake_control and sees only its ports.
`timescale 1ns/1ns
module rtc_power_wake_control_chk
  import rtc_pwr_pkg::*;
(
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input wire logic                       wakeOut,
  input wire logic                       wakeOutEnable,
  input wire logic                       coreVoltageOk,
  input wire rtc_pwr_pkg::power_ctl_type powerCtl
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_down;
    !powerCtl.powerGood && powerCtl.isolation && !powerCtl.systemReset_n && !powerCtl.rtcAccessEnable;
  endsequence
  // System reset outlasts one whole slow tick; four cycles holds for any divider of four or more
  sequence s_sys_held;
    (!powerCtl.systemReset_n) [*4];
  endsequence

  property p_iso; !powerCtl.powerGood |-> powerCtl.isolation && !powerCtl.rtcAccessEnable; endproperty
  property p_good_rise; $rose(powerCtl.powerGood) |-> !powerCtl.isolation && powerCtl.rtcAccessEnable
    && $past(coreVoltageOk, 2); endproperty
  property p_sys_rst; $rose(powerCtl.powerGood) |-> s_sys_held; endproperty
  property p_reg_good; !powerCtl.coreRegulatorEnable |-> !powerCtl.powerGood; endproperty
  property p_por_pair; powerCtl.coreRegulatorEnable == powerCtl.analogPorEnable; endproperty
  property p_bandgap; !powerCtl.bandgapEnable |-> !powerCtl.coreRegulatorEnable; endproperty
  property p_down; $fell(powerCtl.coreRegulatorEnable) |-> s_down; endproperty
  property p_open_drain; wakeOutEnable |-> !wakeOut; endproperty
  property p_ramp; $rose(powerCtl.coreRegulatorEnable) |-> powerCtl.bandgapEnable && !powerCtl.powerGood;
  endproperty

  a_iso:        assert property (p_iso) else $error("isolation open while power-good low");
  a_good_rise:  assert property (p_good_rise) else $error("power-good rose wrongly");
  a_sys_rst:    assert property (p_sys_rst) else $error("system reset too short");
  a_reg_good:   assert property (p_reg_good) else $error("power-good with regulator off");
  a_por_pair:   assert property (p_por_pair) else $error("reset monitor not with regulator");
  a_bandgap:    assert property (p_bandgap) else $error("bandgap off with regulator on");
  a_down:       assert property (p_down) else $error("shutdown state incomplete");
  a_open_drain: assert property (p_open_drain) else $error("wake pin driven high");
  a_ramp:       assert property (p_ramp) else $error("wake ramp state wrong");
endmodule

bind rtc_power_wake_control rtc_power_wake_control_chk chk (
  .clk_sys       (clk_sys),
  .rst_n         (rst_n),
  .wakeOut       (wakeOut),
  .wakeOutEnable (wakeOutEnable),
  .coreVoltageOk (coreVoltageOk),
  .powerCtl      (powerCtl)
);

/* rtc_power_partner.sv */
// Outside power manager and wake source: core supply ramp and wake pulses.
// Assumes the bench resolves the wake pin from this level and the device enable.
`timescale 1ns/1ns
module rtc_power_partner #(
  parameter int unsigned PULSE_CYCLES = 12
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       regulatorOn,
  input  wire logic [7:0] rampCycles,
  input  wire logic       pulseStart,
  input  wire logic       holdHigh,
  output logic            coreVoltageOk,
  output logic            wakeLevel
);
  int unsigned pulseCnt_r;
  logic [7:0]  rampCnt_r;

  // The pulse runs whether or not the core supply is up, so only the pulse length matters here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) pulseCnt_r <= 0;
    else if (pulseStart) pulseCnt_r <= PULSE_CYCLES;
    else if (pulseCnt_r != 0) pulseCnt_r <= pulseCnt_r - 1;
  end
  // Waker drives the line low when idle, so a floating pin never looks like a wake
  assign wakeLevel = holdHigh || (pulseCnt_r != 0);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rampCnt_r <= '0;
    else if (!regulatorOn) rampCnt_r <= '0;
    else if (rampCnt_r < rampCycles) rampCnt_r <= rampCnt_r + 8'h01;
  end
  // Voltage drops at once when the regulator is shut
  assign coreVoltageOk = regulatorOn && (rampCnt_r >= rampCycles);
endmodule

/* rtc_power_wake_control_tb.sv */
// Self-checking bench for the power and wake control.
// Assumes the checker is bound by its own file and the partner models the far side.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin badCount++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module rtc_power_wake_control_tb
  import rtc_pwr_pkg::*;
;
  localparam int TD   = 6;
  localparam int LAND = 3 * TD + 4;
  logic          clk_sys, rst_n, wakeIn, wakeLevel, alarmIrq, coreVoltageOk, pulseStart, holdHigh;
  logic          avmmWaitRequest, wakeOut, wakeOutEnable;
  logic [7:0]    rampCycles;
  logic [15:0]   rnd;
  logic [31:0]   avmmReadData, v;
  avmm_req_type  avmmReq;
  power_ctl_type powerCtl;
  int            badCount, comparisons, expPmgt, i, m, old;

  rtc_power_wake_control #(.TICK_DIV(TD)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .avmmReq(avmmReq), .avmmReadData(avmmReadData),
    .avmmWaitRequest(avmmWaitRequest), .wakeIn(wakeIn), .wakeOut(wakeOut), .wakeOutEnable(wakeOutEnable),
    .alarmIrq(alarmIrq), .coreVoltageOk(coreVoltageOk), .powerCtl(powerCtl));
  rtc_power_partner #(.PULSE_CYCLES(2 * TD)) partner (
    .clk_sys(clk_sys), .rst_n(rst_n), .regulatorOn(powerCtl.coreRegulatorEnable), .rampCycles(rampCycles),
    .pulseStart(pulseStart), .holdHigh(holdHigh), .coreVoltageOk(coreVoltageOk), .wakeLevel(wakeLevel));

  assign wakeIn = wakeOutEnable ? 1'b0 : wakeLevel;
  always #20 clk_sys = ~clk_sys;

  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic giveVerdict();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic busOp(input logic wr, input logic [15:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge clk_sys);
    avmmReq <= '{read: !wr, write: wr, address: a, writedata: wd, byteenable: 4'hf};
    for (n = 0; n < 400; n++) begin
      @(posedge clk_sys);
      if (avmmWaitRequest === 1'b0) break;
    end
    rd = avmmReadData;
    if (n == 400) begin
      badCount++;
      giveVerdict();
    end
    avmmReq.read <= 1'b0;
    avmmReq.write <= 1'b0;
  endtask

  task automatic wrPmgt(input logic [31:0] d);
    logic [31:0] rd;
    busOp(1'b1, PMGT_OFFSET, d, rd);
    expPmgt = int'(d & 32'h1f);
  endtask

  task automatic rdChk(input logic [15:0] a, input int e);
    logic [31:0] rd;
    busOp(1'b0, a, 32'h0, rd);
    `CHK("readData", e, rd)
  endtask

  // Bounded wait for the end of the wake sequence
  task automatic waitRun();
    int n;
    for (n = 0; n < 2000; n++) begin
      @(posedge clk_sys);
      if (powerCtl.systemReset_n === 1'b1 && powerCtl.powerGood === 1'b1) break;
    end
    if (n == 2000) begin
      badCount++;
      giveVerdict();
    end
  endtask

  initial begin
    clk_sys = 1'b0; rst_n = 1'b0; avmmReq = '0; alarmIrq = 1'b0; pulseStart = 1'b0; holdHigh = 1'b0;
    rampCycles = 8'h05; expPmgt = 'h10; rnd = 16'h004d;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdChk(PMGT_OFFSET, expPmgt);
    `CHK("clockOut", 0, powerCtl.clockOutEnable)
    `CHK("wakeDrive", 0, wakeOutEnable)
    rdChk(STATUS_OFFSET, (1 << ST_POWER_GOOD_BIT) | (1 << ST_REG_ON_BIT) | (1 << ST_REF_ON_BIT));
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      rnd = lfsrNext(rnd);
      v = {rnd, rnd} & ~32'h6;
      old = expPmgt;
      wrPmgt(v);
      `CHK("clockOutEarly", old & 1, powerCtl.clockOutEnable)
      repeat (LAND) @(posedge clk_sys);
      rdChk(PMGT_OFFSET, expPmgt);
      `CHK("clockOut", expPmgt & 1, powerCtl.clockOutEnable)
      `CHK("wakeDrive", expPmgt[3] & ~expPmgt[4], wakeOutEnable)
      `CHK("wakeOut", 0, wakeOut)
      rdChk(16'h1938, 0);
    end
    $display("test register done");
    for (m = 0; m < 2; m++) begin
      rampCycles <= m ? 8'd40 : 8'd5;
      wrPmgt(m ? 32'h4 : 32'h2);
      repeat (LAND) @(posedge clk_sys);
      `CHK("regulator", 0, powerCtl.coreRegulatorEnable)
      `CHK("monitor", 0, powerCtl.analogPorEnable)
      rdChk(STATUS_OFFSET, (m ? 0 : 1 << ST_REF_ON_BIT) | (1 << ST_STATE_LSB));
      `CHK("bandgap", m == 0, powerCtl.bandgapEnable)
      `CHK("powerGood", 0, powerCtl.powerGood)
      `CHK("isolation", 1, powerCtl.isolation)
      pulseStart <= 1'b1;
      @(posedge clk_sys);
      pulseStart <= 1'b0;
      repeat (2 * TD + 8) @(posedge clk_sys);
      `CHK("regulator", 1, powerCtl.coreRegulatorEnable)
      if (m) `CHK("powerGood", 0, powerCtl.powerGood)
      waitRun();
      `CHK("access", 1, powerCtl.rtcAccessEnable)
      `CHK("isolation", 0, powerCtl.isolation)
      expPmgt = expPmgt & 'h19;
      rdChk(PMGT_OFFSET, expPmgt);
    end
    $display("test wake pin done");
    // Pin set as output but released, so a high from the waker reaches the pin and must be ignored
    wrPmgt(32'h1a);
    repeat (LAND) @(posedge clk_sys);
    `CHK("wakeDrive", 0, wakeOutEnable)
    holdHigh <= 1'b1;
    repeat (4 * TD) @(posedge clk_sys);
    `CHK("regulator", 0, powerCtl.coreRegulatorEnable)
    rdChk(STATUS_OFFSET, (1 << ST_REF_ON_BIT) | (1 << ST_WAKE_LEVEL_BIT) | (1 << ST_STATE_LSB));
    holdHigh <= 1'b0;
    alarmIrq <= 1'b1;
    repeat (2 * TD + 8) @(posedge clk_sys);
    alarmIrq <= 1'b0;
    `CHK("regulator", 1, powerCtl.coreRegulatorEnable)
    waitRun();
    expPmgt = expPmgt & 'h19;
    rdChk(PMGT_OFFSET, expPmgt);
    $display("test alarm done");
    giveVerdict();
  end
endmodule
